// File: rtl/psc_pkg.sv
// Package: chip states, config sources, carrier structs and timing constants for power-state control
package psc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ = 40000000;
    localparam int unsigned DEBOUNCE_US = 100;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_FREQ_HZ / 1000000) < 1) ? 1 :
        DEBOUNCE_US * (CLK_FREQ_HZ / 1000000);
    localparam int unsigned DB_CNT_W = 16;
    localparam int unsigned OTP_LOAD_CYC = 4096;
    localparam int unsigned LOAD_CNT_W = 16;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic RST_CTL_N = 1'h0;
    localparam logic RST_RETAIN_N = 1'h1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_POR = 2'h0,
        ST_OFF = 2'h1,
        ST_RETAIN = 2'h2,
        ST_RUN = 2'h3
    } psc_state_e;

    typedef enum logic [1:0] {
        SRC_OTP = 2'h0,
        SRC_SPI = 2'h1,
        SRC_MCU = 2'h2
    } psc_src_e;

    typedef enum logic [1:0] {
        CF_IDLE = 2'h0,
        CF_LOAD = 2'h1,
        CF_DONE = 2'h2
    } psc_cfg_e;

    // Requests from the fabric port block while running
    typedef struct packed {
        logic fabric_pwr;
        logic pad_en;
        logic bram_en;
        logic pll_en;
        logic osc_en;
    } psc_fab_s;

    // Power and retention controls towards the analogue side
    typedef struct packed {
        logic array_pwr;
        logic cfg_keep;
        logic pll_en;
        logic osc_en;
        logic otp_en;
        logic bram_keep;
        logic bram_en;
        logic pad_hiz;
        logic pad_hold;
    } psc_ctl_s;

endpackage : psc_pkg

// File: rtl/psc_sync_db.sv
// Two-flop synchroniser followed by a stable-count debouncer
`timescale 1ns/100ps
module psc_sync_db #(
    parameter logic RST_VAL = 1'h0,
    parameter int unsigned CYC = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    logic meta_q;
    logic sync_q;
    logic [psc_pkg::DB_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // Level moves only after CYC equal samples, so a glitch never reaches the decoder
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            level_o <= RST_VAL;
        end else if (sync_q == level_o) begin
            cnt_q <= '0;
        end else if (cnt_q == psc_pkg::DB_CNT_W'(CYC - 1)) begin
            cnt_q <= '0;
            level_o <= sync_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : psc_sync_db

// File: rtl/psc_cfg_load.sv
// Configuration loader: fills volatile configuration from one-time store, SPI or MCU
`timescale 1ns/100ps
module psc_cfg_load #(
    parameter int unsigned OTP_CYC = 4096
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic abort_i,
    input wire psc_pkg::psc_src_e src_i,
    input wire logic ext_done_i,
    // Status
    output logic otp_rd_o,
    output logic busy_o,
    output logic done_o
);
    psc_pkg::psc_cfg_e st_q;
    logic [psc_pkg::LOAD_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            st_q <= psc_pkg::CF_IDLE;
            cnt_q <= '0;
        end else begin
            case (st_q)
                psc_pkg::CF_IDLE: begin
                    cnt_q <= '0;
                    if (start_i) begin
                        st_q <= psc_pkg::CF_LOAD;
                    end
                end
                psc_pkg::CF_LOAD: begin
                    if (src_i == psc_pkg::SRC_OTP) begin
                        // Fixed-length read of the whole store
                        if (cnt_q == psc_pkg::LOAD_CNT_W'(OTP_CYC - 1)) begin
                            st_q <= psc_pkg::CF_DONE;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end else if (ext_done_i) begin
                        st_q <= psc_pkg::CF_DONE;
                    end
                end
                psc_pkg::CF_DONE: st_q <= psc_pkg::CF_DONE;
                default: st_q <= psc_pkg::CF_IDLE;
            endcase
        end
    end

    assign busy_o = (st_q == psc_pkg::CF_LOAD);
    // Store read stops in the cycle the state leaves run, in step with the store enable
    assign otp_rd_o = busy_o && !abort_i && (src_i == psc_pkg::SRC_OTP);
    assign done_o = (st_q == psc_pkg::CF_DONE);
endmodule : psc_cfg_load

// File: rtl/psc_top.sv
// Power-state controller: decodes off/retain pins into chip states and gates power domains
//
// Behaviour
// - Off pin low forces off state: configuration lost, array power gated.
// - Off state disables PLL, oscillator and one-time store.
// - Off state discards block RAM unless keep-at-reset setting is one.
// - Off state tristates pads, no hold, unless pad hold setting is one.
// - Off high, retain low: retention, configuration kept, array power gated.
// - Retention keeps PLL, oscillator and one-time store disabled.
// - Retention keeps block RAM only when both bank-group enables are zero.
// - Retention drives pads out of high impedance and holds their values.
// - Both high: configure from store, SPI or MCU, then follow fabric port block.
// - Power-on reset holds device until both supplies are in range.
// - Power-on reset reasserts whenever either supply drops out of range.
// - Pads are high impedance while power-on reset is active.
// - One-time mode loads the design from the 384 kb store at power-up.
// - Fabric design lives in volatile registers filled from store or SPI.
`timescale 1ns/100ps
module psc_top #(
    parameter int unsigned OTP_LOAD_CYC = psc_pkg::OTP_LOAD_CYC
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Control pins
    input wire logic OFF_CTL_N_I,
    input wire logic RETAIN_LOW_N_I,
    // Supply monitors
    input wire logic VIO_OK_I,
    input wire logic VCORE_OK_I,
    // Settings
    input wire logic BRAM_KEEP_AT_RST_I,
    input wire logic PAD_HOLD_I,
    input wire logic BRAM_LO_REG_EN_I,
    input wire logic BRAM_HI_REG_EN_I,
    input wire psc_pkg::psc_src_e CFG_SRC_I,
    input wire logic EXT_CFG_DONE_I,
    // Fabric port block requests
    input wire psc_pkg::psc_fab_s FAB_REQ_I,
    // Power and retention controls
    output psc_pkg::psc_ctl_s CTL_O,
    // Status
    output psc_pkg::psc_state_e STATE_O,
    output logic POR_ACTIVE_O,
    output logic CFG_LOADED_O,
    output logic OTP_READ_O,
    output logic SPI_PADS_CFG_O
);
    logic off_ctl_n;
    logic retain_low_n;
    logic vio_ok;
    logic vcore_ok;
    logic por_q;
    logic cfg_valid_q;
    logic cfg_start;
    logic cfg_busy;
    logic cfg_done;
    logic otp_rd;
    psc_pkg::psc_state_e state_q;
    psc_pkg::psc_state_e state_d;
    psc_pkg::psc_ctl_s ctl_d;

    // ************************************************************
    // Pin conditioning
    // ************************************************************
    // Debounce on both control pins
    psc_sync_db #(.RST_VAL(psc_pkg::RST_CTL_N), .CYC(psc_pkg::DEBOUNCE_CYC)) u_off_db (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .pin_i(OFF_CTL_N_I),
        .level_o(off_ctl_n)
    );

    psc_sync_db #(.RST_VAL(psc_pkg::RST_RETAIN_N), .CYC(psc_pkg::DEBOUNCE_CYC)) u_ret_db (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .pin_i(RETAIN_LOW_N_I),
        .level_o(retain_low_n)
    );

    // Supply flags are analogue and asynchronous; no debounce so a drop acts fast
    psc_sync_db #(.RST_VAL(1'h0), .CYC(1)) u_vio_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .pin_i(VIO_OK_I),
        .level_o(vio_ok)
    );

    psc_sync_db #(.RST_VAL(1'h0), .CYC(1)) u_vcore_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .pin_i(VCORE_OK_I),
        .level_o(vcore_ok)
    );

    // ************************************************************
    // Power-on reset
    // ************************************************************
    // Held until both rails good, reasserted on any drop
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            por_q <= 1'h1;
        end else begin
            por_q <= !(vio_ok && vcore_ok);
        end
    end

    // ************************************************************
    // Chip state
    // ************************************************************
    always_comb begin
        if (por_q) begin
            state_d = psc_pkg::ST_POR;
        end else if (!off_ctl_n) begin
            state_d = psc_pkg::ST_OFF;
        end else if (!retain_low_n) begin
            state_d = psc_pkg::ST_RETAIN;
        end else begin
            state_d = psc_pkg::ST_RUN;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_q <= psc_pkg::ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Configuration validity
    // ************************************************************
    // Volatile configuration: lost in off and reset, kept through retention
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            cfg_valid_q <= 1'h0;
        end else if (state_q == psc_pkg::ST_POR || state_q == psc_pkg::ST_OFF) begin
            cfg_valid_q <= 1'h0;
        end else if (cfg_done) begin
            cfg_valid_q <= 1'h1;
        end
    end

    // Load starts on entering run with no valid configuration
    assign cfg_start = (state_q == psc_pkg::ST_RUN) && !cfg_valid_q && !cfg_busy;

    psc_cfg_load #(.OTP_CYC(OTP_LOAD_CYC)) u_load (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(cfg_start),
        .abort_i(state_q != psc_pkg::ST_RUN),
        .src_i(CFG_SRC_I),
        .ext_done_i(EXT_CFG_DONE_I),
        .otp_rd_o(otp_rd),
        .busy_o(cfg_busy),
        .done_o(cfg_done)
    );

    // ************************************************************
    // Domain controls
    // ************************************************************
    always_comb begin
        ctl_d = '0;
        case (state_q)
            psc_pkg::ST_POR: begin
                ctl_d.pad_hiz = 1'h1;
            end
            psc_pkg::ST_OFF: begin
                // Array gated, config dropped; PLL, oscillator, store off
                ctl_d.bram_keep = BRAM_KEEP_AT_RST_I;
                ctl_d.pad_hiz = !PAD_HOLD_I;
                ctl_d.pad_hold = PAD_HOLD_I;
            end
            psc_pkg::ST_RETAIN: begin
                ctl_d.cfg_keep = 1'h1;
                // Clock sources and store remain off
                ctl_d.bram_keep = !BRAM_LO_REG_EN_I && !BRAM_HI_REG_EN_I;
                ctl_d.pad_hiz = 1'h0;
                ctl_d.pad_hold = 1'h1;
            end
            psc_pkg::ST_RUN: begin
                ctl_d.cfg_keep = 1'h1;
                ctl_d.otp_en = otp_rd;
                if (cfg_valid_q) begin
                    // Fabric port block owns the domains once configured
                    ctl_d.array_pwr = FAB_REQ_I.fabric_pwr;
                    ctl_d.pll_en = FAB_REQ_I.pll_en;
                    ctl_d.osc_en = FAB_REQ_I.osc_en;
                    ctl_d.bram_en = FAB_REQ_I.bram_en;
                    ctl_d.bram_keep = 1'h1;
                    ctl_d.pad_hiz = !FAB_REQ_I.pad_en;
                end else begin
                    // Array powered for loading; pads stay tristated until configured
                    ctl_d.array_pwr = 1'h1;
                    ctl_d.osc_en = 1'h1;
                    ctl_d.pad_hiz = 1'h1;
                end
            end
            default: begin
                ctl_d.pad_hiz = 1'h1;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            CTL_O <= '{pad_hiz: 1'h1, default: 1'h0};
        end else begin
            CTL_O <= ctl_d;
        end
    end

    // ************************************************************
    // Status
    // ************************************************************
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            POR_ACTIVE_O <= 1'h1;
            CFG_LOADED_O <= 1'h0;
            OTP_READ_O <= 1'h0;
            SPI_PADS_CFG_O <= 1'h0;
        end else begin
            POR_ACTIVE_O <= por_q;
            CFG_LOADED_O <= cfg_valid_q;
            OTP_READ_O <= otp_rd;
            // Host owns SPI pads during an SPI or MCU load
            SPI_PADS_CFG_O <= cfg_busy && (CFG_SRC_I != psc_pkg::SRC_OTP);
        end
    end

    assign STATE_O = state_q;
endmodule : psc_top

// File: verif/psc_chk.sv
// Checker: port-level assertions for the power-state controller
`timescale 1ns/100ps
module psc_chk (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Pins, supplies and settings
    input wire logic OFF_CTL_N_I,
    input wire logic RETAIN_LOW_N_I,
    input wire logic VIO_OK_I,
    input wire logic VCORE_OK_I,
    input wire logic BRAM_KEEP_AT_RST_I,
    input wire logic PAD_HOLD_I,
    input wire logic BRAM_LO_REG_EN_I,
    input wire logic BRAM_HI_REG_EN_I,
    input wire psc_pkg::psc_fab_s FAB_REQ_I,
    // Outputs
    input wire psc_pkg::psc_ctl_s CTL_O,
    input wire psc_pkg::psc_state_e STATE_O,
    input wire logic CFG_LOADED_O,
    input wire logic OTP_READ_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    // Cycles each pin has stood still, saturating; each state change answers to one pin only
    logic [15:0] stab_off_q;
    logic [15:0] stab_ret_q;
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || $changed(OFF_CTL_N_I)) begin
            stab_off_q <= 16'h0000;
        end else if (stab_off_q != 16'hFFFF) begin
            stab_off_q <= stab_off_q + 16'h0001;
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || $changed(RETAIN_LOW_N_I)) begin
            stab_ret_q <= 16'h0000;
        end else if (stab_ret_q != 16'hFFFF) begin
            stab_ret_q <= stab_ret_q + 16'h0001;
        end
    end
    AST_OFF_GATE: assert property (STATE_O == psc_pkg::ST_OFF |=>
        !CTL_O.array_pwr && !CTL_O.cfg_keep && !CTL_O.pll_en && !CTL_O.osc_en && !CTL_O.otp_en)
        else $error("off state left a domain powered");
    AST_OFF_BRAM: assert property (STATE_O == psc_pkg::ST_OFF |=>
        CTL_O.bram_keep == $past(BRAM_KEEP_AT_RST_I)) else $error("off state bram keep wrong");
    AST_OFF_PAD: assert property (STATE_O == psc_pkg::ST_OFF |=>
        CTL_O.pad_hiz != $past(PAD_HOLD_I) && CTL_O.pad_hold == $past(PAD_HOLD_I))
        else $error("off state pad control wrong");
    AST_RET_GATE: assert property (STATE_O == psc_pkg::ST_RETAIN |=>
        CTL_O.cfg_keep && !CTL_O.array_pwr && !CTL_O.pll_en && !CTL_O.osc_en && !CTL_O.otp_en)
        else $error("retention gating wrong");
    AST_RET_BRAM: assert property (STATE_O == psc_pkg::ST_RETAIN |=>
        CTL_O.bram_keep == !($past(BRAM_LO_REG_EN_I) || $past(BRAM_HI_REG_EN_I)))
        else $error("retention bram keep wrong");
    AST_RET_PAD: assert property (STATE_O == psc_pkg::ST_RETAIN |=>
        !CTL_O.pad_hiz && CTL_O.pad_hold) else $error("retention pads not held");
    AST_RUN_FAB: assert property (CFG_LOADED_O && $past(STATE_O) == psc_pkg::ST_RUN |->
        CTL_O.pll_en == $past(FAB_REQ_I.pll_en) && CTL_O.osc_en == $past(FAB_REQ_I.osc_en)
        && CTL_O.array_pwr == $past(FAB_REQ_I.fabric_pwr)) else $error("run ignores fabric");
    AST_SUP_DROP: assert property ($fell(VIO_OK_I && VCORE_OK_I) |->
        ##[1:6] STATE_O == psc_pkg::ST_POR) else $error("supply drop without reset");
    AST_POR_HIZ: assert property (STATE_O == psc_pkg::ST_POR |=> CTL_O.pad_hiz)
        else $error("pads driven in power-on reset");
    AST_OTP_RD: assert property (OTP_READ_O == CTL_O.otp_en
        && (!OTP_READ_O || $past(STATE_O) == psc_pkg::ST_RUN))
        else $error("store read flag out of step");
    AST_DEBOUNCE: assert property ($changed(STATE_O) && STATE_O != psc_pkg::ST_POR
        && $past(STATE_O) != psc_pkg::ST_POR |-> ((STATE_O == psc_pkg::ST_OFF
        || $past(STATE_O) == psc_pkg::ST_OFF) ? stab_off_q : stab_ret_q)
        >= psc_pkg::DEBOUNCE_CYC) else $error("state moved on unsettled pins");
    COV_RET: cover property (STATE_O == psc_pkg::ST_RETAIN);
    COV_LOAD: cover property ($rose(CFG_LOADED_O));
    COV_HOLD: cover property (STATE_O == psc_pkg::ST_OFF && PAD_HOLD_I);
endmodule : psc_chk

bind psc_top psc_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .OFF_CTL_N_I(OFF_CTL_N_I),
    .RETAIN_LOW_N_I(RETAIN_LOW_N_I), .VIO_OK_I(VIO_OK_I), .VCORE_OK_I(VCORE_OK_I),
    .BRAM_KEEP_AT_RST_I(BRAM_KEEP_AT_RST_I), .PAD_HOLD_I(PAD_HOLD_I),
    .BRAM_LO_REG_EN_I(BRAM_LO_REG_EN_I), .BRAM_HI_REG_EN_I(BRAM_HI_REG_EN_I),
    .FAB_REQ_I(FAB_REQ_I), .CTL_O(CTL_O), .STATE_O(STATE_O), .CFG_LOADED_O(CFG_LOADED_O),
    .OTP_READ_O(OTP_READ_O));

// File: verif/psc_host_mdl.sv
// Host model: drives the two control pins and answers external loads
`timescale 1ns/100ps
module psc_host_mdl #(
    parameter int unsigned DONE_LAT = 6
) (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic off_req_i,
    input wire logic retain_req_i,
    input wire logic load_busy_i,
    // Towards the device
    output logic off_n_o,
    output logic retain_n_o,
    output logic done_o
);
    int unsigned cnt = 0;
    initial begin
        off_n_o = 1'h1;
        retain_n_o = 1'h1;
        done_o = 1'h0;
    end
    // Pins move on the falling edge, clear of sampling
    always @(negedge clk_i) begin
        off_n_o <= !off_req_i;
        retain_n_o <= !retain_req_i;
        cnt <= load_busy_i ? cnt + 1 : 0;
        done_o <= load_busy_i && (cnt >= DONE_LAT);
    end
endmodule : psc_host_mdl

// File: verif/psc_top_tb_top.sv
// Testbench: walks the controller through its chip states
`timescale 1ns/100ps
module psc_top_tb_top;
    localparam int unsigned OTP_CYC = 8;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic vio_ok = 1'h0;
    logic vcore_ok = 1'h0;
    logic keep = 1'h0;
    logic hold = 1'h0;
    logic lo_en = 1'h0;
    logic hi_en = 1'h0;
    logic off_req = 1'h0;
    logic ret_req = 1'h0;
    logic saw_otp;
    logic saw_spi;
    int otp_n = 0;
    psc_pkg::psc_src_e src = psc_pkg::SRC_OTP;
    psc_pkg::psc_fab_s fab = 5'h1F;
    psc_pkg::psc_ctl_s ctl;
    psc_pkg::psc_state_e st;
    logic por_act, loaded, otp_rd, spi_cfg, off_n, ret_n, ext_done;
    int err_total = 0;
    int checked = 0;

    psc_top #(.OTP_LOAD_CYC(OTP_CYC)) DUT (.REF_CLK_I(clk), .RST_I(rst), .OFF_CTL_N_I(off_n),
        .RETAIN_LOW_N_I(ret_n), .VIO_OK_I(vio_ok), .VCORE_OK_I(vcore_ok),
        .BRAM_KEEP_AT_RST_I(keep), .PAD_HOLD_I(hold), .BRAM_LO_REG_EN_I(lo_en),
        .BRAM_HI_REG_EN_I(hi_en), .CFG_SRC_I(src), .EXT_CFG_DONE_I(ext_done),
        .FAB_REQ_I(fab), .CTL_O(ctl), .STATE_O(st), .POR_ACTIVE_O(por_act),
        .CFG_LOADED_O(loaded), .OTP_READ_O(otp_rd), .SPI_PADS_CFG_O(spi_cfg));
    psc_host_mdl u_host (.clk_i(clk), .off_req_i(off_req), .retain_req_i(ret_req),
        .load_busy_i(spi_cfg), .off_n_o(off_n), .retain_n_o(ret_n), .done_o(ext_done));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Debounce takes 4000 cycles, so the bound sits well above it
    task automatic wait_st(input psc_pkg::psc_state_e s);
        int n;
        n = 0;
        while (st !== s && n < 6000) begin
            @(negedge clk);
            n++;
        end
        chk("state", 9'(s), 9'(st));
    endtask : wait_st
    task automatic wait_ld();
        int n;
        n = 0;
        saw_otp = 1'h0;
        saw_spi = 1'h0;
        otp_n = 0;
        while (loaded !== 1'h1 && n < 100) begin
            @(negedge clk);
            saw_otp = saw_otp | otp_rd;
            otp_n = otp_n + int'(otp_rd);
            saw_spi = saw_spi | spi_cfg;
            n++;
        end
        chk("loaded", 9'h001, 9'(loaded));
    endtask : wait_ld
    task automatic fab_chk(input psc_pkg::psc_fab_s v);
        fab = v;
        repeat (3) @(negedge clk);
        chk("fab_ctl", {v.fabric_pwr, 1'b1, v.pll_en, v.osc_en, 1'b0, 1'b1, v.bram_en,
            !v.pad_en, 1'b0}, ctl);
    endtask : fab_chk
    task automatic give_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'h0;
        repeat (20) @(negedge clk);
        chk("por_act", 9'h001, 9'(por_act));
        chk("por_hiz", 9'h001, 9'(ctl.pad_hiz));
        $display("test por done");
        vio_ok = 1'h1;
        vcore_ok = 1'h1;
        wait_st(psc_pkg::ST_RUN);
        wait_ld();
        chk("otp_rd", 9'h001, 9'(saw_otp));
        chk("otp_len", 9'(OTP_CYC), 9'(otp_n));
        fab_chk(5'h15);
        fab_chk(5'h0A);
        $display("test otp run done");
        // Pulse well short of the debounce span
        off_req = 1'h1;
        repeat (200) @(negedge clk);
        off_req = 1'h0;
        repeat (4100) @(negedge clk);
        chk("glitch", 9'(psc_pkg::ST_RUN), 9'(st));
        $display("test glitch done");
        ret_req = 1'h1;
        wait_st(psc_pkg::ST_RETAIN);
        for (int i = 0; i < 4; i++) begin
            {hi_en, lo_en} = i[1:0];
            repeat (3) @(negedge clk);
            chk("ret_ctl", {5'b01000, i == 0, 3'b001}, ctl);
        end
        ret_req = 1'h0;
        wait_st(psc_pkg::ST_RUN);
        repeat (3) @(negedge clk);
        chk("cfg_kept", 9'h001, 9'(loaded));
        $display("test retention done");
        off_req = 1'h1;
        wait_st(psc_pkg::ST_OFF);
        for (int i = 0; i < 4; i++) begin
            {hold, keep} = i[1:0];
            repeat (3) @(negedge clk);
            chk("off_ctl", {5'b00000, keep, 1'b0, !hold, hold}, ctl);
        end
        chk("off_cfg", 9'h000, 9'(loaded));
        $display("test off done");
        for (int i = 1; i < 3; i++) begin
            src = psc_pkg::psc_src_e'(i);
            off_req = 1'h0;
            wait_st(psc_pkg::ST_RUN);
            wait_ld();
            chk("ext_load", 9'h001, 9'(saw_spi));
            chk("ext_otp", 9'h000, 9'(otp_n));
            off_req = 1'h1;
            wait_st(psc_pkg::ST_OFF);
        end
        $display("test external load done");
        vcore_ok = 1'h0;
        repeat (8) @(negedge clk);
        chk("drop_st", 9'(psc_pkg::ST_POR), 9'(st));
        chk("drop_hiz", 9'h001, 9'(ctl.pad_hiz));
        vcore_ok = 1'h1;
        wait_st(psc_pkg::ST_OFF);
        vio_ok = 1'h0;
        repeat (8) @(negedge clk);
        chk("vio_drop", 9'(psc_pkg::ST_POR), 9'(st));
        vio_ok = 1'h1;
        wait_st(psc_pkg::ST_OFF);
        $display("test supply drop done");
        give_verdict();
    end

    // Whole run is near 36400 cycles
    initial begin
        #1500000;
        err_total++;
        $display("[ERR] watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule : psc_top_tb_top
